// [core/hbd_defines.vh]
// Operation
// R1 - Delay acknowledge 20 clocks after service events.
// R2 - Host without acknowledge waits out hold-off.
// R3 - Cycle after second edge past reset is C1.
// R4 - Async DMA timing only when config bit set.
// R5 - Async mode samples acknowledge fall on clock.
// R6 - Controller holds DMA acknowledge three clocks minimum.
// R7 - Long acknowledge keeps bus driven until release.
// R8 - Short acknowledge still releases after third edge.
// R9 - Read data valid after C2 edge.
// R10 - Transfer acknowledge asserted after C3 edge.
// R11 - Host sets address before C1 edge.
// R12 - Release acknowledge when select and strobe high.
`ifndef HBD_DEFINES_VH
`define HBD_DEFINES_VH
// Hold-off after a service acknowledge or end-of-service write, in clocks.
`define HBD_HOLDOFF_CLKS 20
// Position of the asynchronous DMA enable in the port configuration word.
`define HBD_ASYNC_DMA_BIT 1
// Clock edges after reset release before cycle numbering starts.
`define HBD_RESET_EDGES 2
// Least asynchronous DMA acknowledge active time, in clocks.
`define HBD_DMA_MIN_CLKS 3
// Edge after acknowledge fall from which acknowledge controls release.
`define HBD_DMA_HOLD_EDGE 2
`endif

// [core/hbd_holdoff.v]
`timescale 1ns/100ps
`include "hbd_defines.vh"
// Counts down the acknowledge hold-off after a service event.
module hbd_holdoff #(
  parameter CLKS = `HBD_HOLDOFF_CLKS
) (
  input wire clk,
  input wire rst,
  input wire arm,
  input wire start,
  output wire busy
);
  // Set when a service event occurred; the next access starts counting.
  reg armed;
  // Remaining hold-off clocks.
  reg [5:0] count;

  // Arm on the event, load the count when the next access begins.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
      count <= 6'h00;
    end else begin
      if (start && armed) begin
        armed <= 1'b0;
        count <= CLKS[5:0]; // R1
      end else if (count != 6'h00) begin
        count <= count - 6'h01;
      end
      if (arm) begin
        armed <= 1'b1;
      end
    end
  end

  // Busy while counting, or in the first cycle of a held-off access.
  assign busy = (count != 6'h00) || (start && armed); // R1
endmodule

// [core/hbd_host_port.v]
`timescale 1ns/100ps
`include "hbd_defines.vh"
// Host bus and slave DMA handshake sequencer.
module hbd_host_port #(
  parameter DW = 16
) (
  input wire clk,
  input wire rst,
  input wire chip_select_n,
  input wire daisy_grant_n,
  input wire data_strobe_n,
  input wire read_not_write,
  input wire service_ack_n,
  input wire eos_write,
  input wire [7:0] port_config_reg,
  input wire dma_req_pending,
  input wire dma_ack_n,
  input wire [DW-1:0] read_word,
  input wire [DW-1:0] host_data_in,
  output reg [DW-1:0] host_data_out,
  output reg host_data_oe,
  output wire transfer_ack_n,
  output reg transfer_ack_oe,
  output reg dma_req_n,
  output reg cycle_c1,
  output reg [DW-1:0] write_word,
  output reg write_strobe,
  output reg read_strobe
);
  // Host access states.
  localparam S_IDLE = 3'h0;
  localparam S_C1 = 3'h1;
  localparam S_C2 = 3'h2;
  localparam S_C3 = 3'h3;
  localparam S_WAIT = 3'h4;
  localparam S_DONE = 3'h5;
  reg [2:0] state;
  reg [2:0] next_state;
  // Edges counted since reset release for cycle numbering.
  reg [1:0] rst_edges;
  // Previous DMA acknowledge level for edge detection.
  reg dma_ack_q;
  // Clock edges since DMA acknowledge fell.
  reg [2:0] dma_edges;
  // High while a DMA cycle is in progress.
  reg dma_active;
  // Asserted acknowledge level.
  reg ack;
  // Hold-off busy from the counter.
  wire hold_busy;
  // Access is being requested by the host.
  wire selected;
  // Asynchronous DMA timing selected.
  wire async_dma;
  // Falling edge of the DMA acknowledge seen on a rising clock.
  wire dma_fall;
  // Last access was a service acknowledge cycle.
  reg svc_cycle;
  // Service event that arms the acknowledge hold-off.
  wire holdoff_arm;
  // DMA acknowledge has ended after its least active time.
  wire dma_done;

  assign selected = (!chip_select_n || !daisy_grant_n) && !data_strobe_n;
  assign async_dma = port_config_reg[`HBD_ASYNC_DMA_BIT]; // R4
  assign dma_fall = dma_ack_q && !dma_ack_n; // R5
  assign transfer_ack_n = !ack;
  // An end-of-service write arms at once; a service cycle arms as it ends,
  // so that the service cycle itself is not held off.
  assign holdoff_arm = eos_write ||
    (svc_cycle && state == S_DONE && next_state == S_IDLE); // R1
  // Release needs the acknowledge high and the third edge reached, so a
  // short acknowledge still leaves the read data up for two clocks.
  assign dma_done = dma_active && dma_ack_n // R7
    && (dma_edges >= `HBD_DMA_MIN_CLKS); // R8

  // Hold-off counter, armed by service acknowledge and end-of-service.
  hbd_holdoff #(
    .CLKS(`HBD_HOLDOFF_CLKS)
  ) u_holdoff (
    .clk(clk),
    .rst(rst),
    .arm(holdoff_arm),
    .start(state == S_C1),
    .busy(hold_busy)
  );

  // Count two edges after reset release, then mark C1.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_edges <= 2'h0;
      cycle_c1 <= 1'b0;
    end else begin
      cycle_c1 <= 1'b0;
      // Stop counting once numbering has begun.
      if (rst_edges != `HBD_RESET_EDGES) begin
        rst_edges <= rst_edges + 2'h1;
        cycle_c1 <= (rst_edges == `HBD_RESET_EDGES - 1); // R3
      end
    end
  end

  // Next state of the host access sequence.
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        // Accesses before cycle numbering starts are ignored.
        if (selected && rst_edges == `HBD_RESET_EDGES) begin
          next_state = S_C1; // R11
        end
      end
      S_C1: begin
        next_state = S_C2;
      end
      S_C2: begin
        next_state = S_C3; // R9
      end
      S_C3: begin
        next_state = hold_busy ? S_WAIT : S_DONE; // R10
      end
      S_WAIT: begin
        if (!hold_busy) begin
          next_state = S_DONE; // R1
        end
      end
      S_DONE: begin
        if (!selected) begin
          next_state = S_IDLE; // R12
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // Sequencer, acknowledge and write capture.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      ack <= 1'b0;
      transfer_ack_oe <= 1'b0;
      write_word <= {DW{1'b0}};
      write_strobe <= 1'b0;
      read_strobe <= 1'b0;
      svc_cycle <= 1'b0;
    end else begin
      state <= next_state;
      write_strobe <= 1'b0;
      read_strobe <= 1'b0;
      // Acknowledge on entry to the done state; a write is handed on there.
      if (next_state == S_DONE && state != S_DONE) begin
        ack <= 1'b1; // R10
        transfer_ack_oe <= 1'b1;
        if (!read_not_write) begin
          write_strobe <= 1'b1;
        end
      end else if (next_state == S_IDLE) begin
        // Select and strobe are gone: let the acknowledge go.
        ack <= 1'b0; // R12
        transfer_ack_oe <= 1'b0;
      end
      // A read fetches its word one clock before it is driven.
      if (state == S_C1 && read_not_write) begin
        read_strobe <= 1'b1;
      end
      // Write data is set up before the C1 edge, so take it there.
      if (state == S_C1 && !read_not_write) begin
        write_word <= host_data_in;
      end
      // Note whether this access is a service acknowledge cycle.
      if (state == S_IDLE && next_state == S_C1) begin
        svc_cycle <= !service_ack_n;
      end
    end
  end

  // DMA handshake: request, acknowledge edge count and bus release.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_ack_q <= 1'b1;
      dma_edges <= 3'h0;
      dma_active <= 1'b0;
      dma_req_n <= 1'b1;
    end else begin
      dma_ack_q <= dma_ack_n;
      dma_req_n <= !dma_req_pending;
      // Start on the sampled falling edge, or on the low level when synchronous.
      if (async_dma ? dma_fall : !dma_ack_n && !dma_active) begin
        dma_active <= 1'b1; // R5
        dma_edges <= 3'h1;
      end else if (dma_active) begin
        // Count edges, stopping at the top so a long hold cannot wrap.
        if (dma_edges != 3'h7) begin
          dma_edges <= dma_edges + 3'h1;
        end
        // Close the cycle once the acknowledge has let go.
        if (dma_done) begin
          dma_active <= 1'b0; // R8
        end
      end
    end
  end

  // Read data driver for host reads and DMA reads.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      host_data_out <= {DW{1'b0}};
      host_data_oe <= 1'b0;
    end else begin
      // Host reads drive at the C2 edge, DMA reads one edge after start.
      if (state == S_C2 && read_not_write) begin
        host_data_out <= read_word; // R9
        host_data_oe <= 1'b1;
      end else if (dma_active && read_not_write && dma_edges == 3'h1) begin
        host_data_out <= read_word; // R5
        host_data_oe <= 1'b1;
      end else if (!selected && (!dma_active || dma_done)) begin
        host_data_oe <= 1'b0; // R7
      end
    end
  end
endmodule

// [verification/hbd_host_port_assertions.sv]
`timescale 1ns/100ps
// Watches the host and DMA handshake timing at the port's pins.
module hbd_host_port_checker (
  input wire clk,
  input wire rst,
  input wire chip_select_n,
  input wire data_strobe_n,
  input wire daisy_grant_n,
  input wire read_not_write,
  input wire service_ack_n,
  input wire eos_write,
  input wire [7:0] port_config_reg,
  input wire dma_ack_n,
  input wire [15:0] read_word,
  input wire [15:0] host_data_out,
  input wire host_data_oe,
  input wire transfer_ack_n,
  input wire cycle_c1
);
  wire sel = !chip_select_n && !data_strobe_n; // A chip-selected host access is open.
  reg hold; // A hold-off is pending.
  reg [5:0] cnt; // Clocks spent in the current access.
  // Tracks service events and access length.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hold <= 1'b0;
      cnt <= 6'h00;
    end else begin
      cnt <= sel ? cnt + 6'h01 : 6'h00;
      if (eos_write || $rose(service_ack_n)) hold <= 1'b1;
      else if (!transfer_ack_n && sel) hold <= 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_start;
    $rose(sel);
  endsequence
  a_ack_not_early: assert property (s_start |-> transfer_ack_n [*4])
    else $error("ack too early");
  a_ack_in_time: assert property (
    s_start ##0 !hold |-> ##4 !transfer_ack_n) else $error("ack late");
  a_holdoff_wait: assert property (
    hold && sel && !transfer_ack_n |-> cnt >= 6'h14) else $error("no hold");
  a_ack_release: assert property (
    data_strobe_n && chip_select_n && daisy_grant_n |=> transfer_ack_n)
    else $error("ack kept");
  a_read_data: assert property (
    s_start ##0 read_not_write |-> ##3 host_data_oe
    && host_data_out == read_word) else $error("read data late");
  a_c1_mark: assert property (
    $fell(rst) |-> !cycle_c1 [*2] ##1 cycle_c1 ##1 !cycle_c1)
    else $error("cycle one misplaced");
  a_dma_long: assert property (
    (port_config_reg[1] && read_not_write && !dma_ack_n) [*4]
    |-> host_data_oe) else $error("bus dropped");
  a_dma_short: assert property (
    port_config_reg[1] ##0 $fell(dma_ack_n) ##1 dma_ack_n
    |-> ##1 host_data_oe ##2 !host_data_oe) else $error("bus not released");
endmodule
bind hbd_host_port hbd_host_port_checker chk (.*);

// [verification/hbd_dma_ctrl.sv]
`timescale 1ns/100ps
// DMA controller: answers each request with one acknowledge pulse.
module hbd_dma_ctrl (
  input wire clk,
  input wire dma_req_n,
  input wire [3:0] hold_clks,
  output reg dma_ack_n
);
  reg [3:0] left = 4'h0; // Clocks of acknowledge still to run.
  initial dma_ack_n = 1'b1;
  // Holds the acknowledge low for hold_clks clocks.
  always @(posedge clk) begin
    if (left != 4'h0) begin
      left <= left - 4'h1;
      dma_ack_n <= (left == 4'h1);
    end else if (!dma_req_n && dma_ack_n) begin
      left <= hold_clks;
      dma_ack_n <= 1'b0;
    end
  end
endmodule

// [verification/test_host_bus_dma_handshake_timing.sv]
`timescale 1ns/100ps
// Drives host and DMA traffic into the port and judges the answers.
module test_host_bus_dma_handshake_timing;
  reg clk = 1'b0, rst = 1'b1, chip_select_n = 1'b1, daisy_grant_n = 1'b1;
  reg data_strobe_n = 1'b1, read_not_write = 1'b1, service_ack_n = 1'b1;
  reg eos_write = 1'b0, dma_req_pending = 1'b0;
  reg [7:0] port_config_reg = 8'h00;
  reg [15:0] read_word = 16'ha5c3;
  reg [15:0] host_data_in = 16'h3c5a;
  reg [3:0] hold_clks = 4'h6;
  wire [15:0] host_data_out, write_word;
  wire host_data_oe, transfer_ack_n, transfer_ack_oe, dma_req_n, cycle_c1;
  wire write_strobe, read_strobe, dma_ack_n;
  integer n_mismatch = 0, checked = 0, cyc = 0, n;
  integer n_rd = 0, n_wr = 0;
  hbd_host_port dut (.*);
  hbd_dma_ctrl dma (.*);
  initial forever #10 clk = ~clk;
  // Counts read and write strobes handed to the register side.
  always @(posedge clk) begin
    if (read_strobe === 1'b1) n_rd <= n_rd + 1;
    if (write_strobe === 1'b1) n_wr <= n_wr + 1;
  end
  task chk(input ok);
    begin
      checked = checked + 1;
      if (ok !== 1'b1) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: wrong answer", $time);
      end
    end
  endtask
  // One host access; svc turns it into a service acknowledge cycle.
  task access(input rw, input svc);
    integer rd0, wr0;
    begin
      @(posedge clk);
      rd0 = n_rd;
      wr0 = n_wr;
      read_not_write <= rw;
      chip_select_n <= svc;
      daisy_grant_n <= !svc;
      service_ack_n <= !svc;
      data_strobe_n <= 1'b0;
      n = 0;
      while (transfer_ack_n !== 1'b0 && n < 40) begin
        @(posedge clk) #1;
        n = n + 1;
      end
      chk(transfer_ack_oe === 1'b1);
      chk(!rw || svc || (host_data_oe && host_data_out === read_word));
      chk(rw || write_word === host_data_in);
      @(posedge clk);
      {chip_select_n, daisy_grant_n, service_ack_n, data_strobe_n} <= 4'hf;
      @(posedge clk) #1;
      chk(transfer_ack_n === 1'b1 && host_data_oe === 1'b0);
      chk(transfer_ack_oe === 1'b0);
      chk(n_rd === rd0 + rw && n_wr === wr0 + !rw);
    end
  endtask
  // Plain read and write take the acknowledge after the C3 edge.
  task t_plain;
    begin
      access(1'b1, 1'b0);
      chk(n === 4);
      access(1'b0, 1'b0);
      chk(n === 4);
      $display("plain access test done");
    end
  endtask
  // Service events hold the next acknowledge off for twenty clocks.
  task t_holdoff;
    begin
      @(posedge clk);
      eos_write <= 1'b1;
      @(posedge clk);
      eos_write <= 1'b0;
      access(1'b1, 1'b0);
      chk(n >= 20 && n < 40);
      access(1'b1, 1'b0);
      chk(n === 4);
      access(1'b1, 1'b1);
      chk(n === 4);
      access(1'b0, 1'b0);
      chk(n >= 20 && n < 40);
      $display("hold-off test done");
    end
  endtask
  // DMA read with an acknowledge of len clocks, async or not as cfg sets.
  task t_dma(input [3:0] len, input oe, input [7:0] cfg);
    begin
      @(posedge clk);
      port_config_reg <= cfg;
      read_not_write <= 1'b1;
      hold_clks <= len;
      dma_req_pending <= 1'b1;
      @(posedge clk);
      dma_req_pending <= 1'b0;
      n = 0;
      while (dma_ack_n !== 1'b0 && n < 20) begin
        @(posedge clk) #1;
        n = n + 1;
      end
      repeat (2) @(posedge clk);
      #1;
      chk(host_data_oe === 1'b1 && host_data_out === read_word);
      repeat (2) @(posedge clk);
      #1;
      chk(host_data_oe === oe);
      repeat (3) @(posedge clk);
      #1;
      chk(host_data_oe === 1'b0);
      $display("dma test done");
    end
  endtask
  task wrap_up;
    begin
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    #10 rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_plain;
    t_holdoff;
    t_dma(4'h6, 1'b1, 8'h02);
    t_dma(4'h1, 1'b0, 8'h02);
    t_dma(4'h6, 1'b1, 8'h00);
    wrap_up;
  end
endmodule
